/* File: rtl/latod_pkg.sv */
package latod_pkg;
   // opcode high bytes of the literal group
   localparam logic [7:0] OPC_SUB_LIT = 8'h08;
   localparam logic [7:0] OPC_OR_LIT = 8'h09;
   localparam logic [7:0] OPC_XOR_LIT = 8'h0A;
   localparam logic [7:0] OPC_AND_LIT = 8'h0B;
   localparam logic [7:0] OPC_RET_LIT = 8'h0C;
   localparam logic [7:0] OPC_MUL_LIT = 8'h0D;
   localparam logic [7:0] OPC_LOAD_LIT = 8'h0E;
   localparam logic [7:0] OPC_ADD_LIT = 8'h0F;
   // opcode fields of 4 to 13 bits
   localparam logic [11:0] OPC_LOAD_BANK = 12'h010;
   localparam logic [9:0] OPC_PTR_FIRST = 10'h3B8;
   localparam logic [7:0] OPC_PTR_SECOND = 8'hF0;
   localparam logic [12:0] OPC_TABLE = 13'h0001;
   localparam logic [5:0] OPC_ADD_FILE = 6'h09;
   localparam logic [3:0] OPC_SECOND_WORD = 4'hF;
   // table pointer actions
   localparam logic [1:0] TBL_NONE = 2'h0;
   localparam logic [1:0] TBL_POST_INC = 2'h1;
   localparam logic [1:0] TBL_POST_DEC = 2'h2;
   localparam logic [1:0] TBL_PRE_INC = 2'h3;
   // flag positions and groups
   localparam int FLG_C = 0;
   localparam int FLG_DC = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_OV = 3;
   localparam int FLG_N = 4;
   localparam logic [4:0] FLAGS_ARITH = 5'h1F;
   localparam logic [4:0] FLAGS_LOGIC = 5'h14;
   localparam logic [4:0] FLAGS_NONE = 5'h00;
   // data memory layout
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   localparam logic [11:0] TIMER_COUNT_ADDR = 12'hFD6;
   localparam logic [11:0] PORT_FIRST_ADDR = 12'hF80;
   localparam logic [11:0] PORT_LAST_ADDR = 12'hF8A;
   localparam int TPTR_W = 22;
   localparam int NUM_PTR = 3;
   // register map, byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_WORK = 8'h04;
   localparam logic [7:0] REG_FLAGS = 8'h08;
   localparam logic [7:0] REG_BANK = 8'h0C;
   localparam logic [7:0] REG_PROD = 8'h10;
   localparam logic [7:0] REG_TPTR = 8'h14;
   localparam logic [7:0] REG_TLAT = 8'h18;
   localparam logic [7:0] REG_PTR0 = 8'h1C;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ALU_PASS, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR
   } latod_aluop_e;

   typedef enum logic [1:0] {
      ST_EXEC, ST_NOP2, ST_TBL2, ST_PTR2
   } latod_state_e;

   typedef struct packed {
      latod_state_e st;
      logic halt;
      logic [7:0] working_register;
      logic [4:0] flags;
      logic [3:0] bank_select_register;
      logic [15:0] prod;
      logic [TPTR_W-1:0] tptr;
      logic [7:0] tlat;
      logic [NUM_PTR-1:0][11:0] ptr;
      logic [1:0] ptr_sel;
      logic [3:0] ptr_hi;
      logic [1:0] tbl_mode;
      logic tbl_wr;
      logic tbl_rd_en;
      logic tbl_wr_en;
      logic [TPTR_W-1:0] tbl_addr;
      logic ret_p;
      logic psc_clr;
      logic dm_we;
      logic [11:0] dm_addr;
      logic [7:0] dm_wdata;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } latod_s;

   localparam latod_s LATOD_RST = '0;
endpackage : latod_pkg

/* File: rtl/latod_alu.sv */
`timescale 1ns/100ps
module latod_alu (
   // operation and operands
   input wire latod_pkg::latod_aluop_e op,
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   // result and flags
   output logic [7:0] res,
   output logic [4:0] flags
);
   import latod_pkg::*;

   logic [8:0] sum;
   logic [4:0] nib;
   logic [8:0] dif;
   logic [4:0] nibd;

   // subtract as b plus inverted a plus one: carry out means no borrow
   assign sum = {1'b0, a} + {1'b0, b};
   assign nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
   assign dif = {1'b0, b} + {1'b0, ~a} + 9'h001;
   assign nibd = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;

   // result and flags per operation
   always_comb begin
      res = b;
      flags = 5'h00;
      case (op)
         ALU_ADD: begin
            res = sum[7:0];
            flags[FLG_C] = sum[8];
            flags[FLG_DC] = nib[4];
            flags[FLG_OV] = (a[7] == b[7]) && (sum[7] != a[7]);
         end
         ALU_SUB: begin
            res = dif[7:0];
            flags[FLG_C] = dif[8];
            flags[FLG_DC] = nibd[4];
            flags[FLG_OV] = (a[7] != b[7]) && (dif[7] != b[7]);
         end
         ALU_AND: res = a & b;
         ALU_OR: res = a | b;
         ALU_XOR: res = a ^ b;
         default: res = b;
      endcase
      flags[FLG_Z] = (res == 8'h00);
      flags[FLG_N] = res[7];
   end
endmodule : latod_alu

/* File: rtl/latod_decoder.sv */
// Functional notes
// RQ1: add-literal adds literal to working register, updates all five flags.
// RQ2: and-literal ANDs literal into working register, only zero and negative.
// RQ3: or-literal ORs literal into working register, only zero and negative.
// RQ4: load-pointer takes two words; selects pointer, loads 12-bit value.
// RQ5: load-bank puts 4-bit literal in bank select register, no flags.
// RQ6: load-literal copies literal to working register, flags unchanged.
// RQ7: multiply-literal multiplies literal by working register, flags unchanged.
// RQ8: return-literal loads working register, returns, two cycles, no flags.
// RQ9: subtract-from-literal puts literal minus working register, all flags.
// RQ10: xor-literal XORs literal into working register, zero and negative.
// RQ11: table read takes two cycles, no flags, low bits pick pointer action.
// RQ12: table write takes two cycles, no flags, low bits pick pointer action.
// RQ13: read-modify-write of port register uses pin level as source.
// RQ14: writing first timer count clears its prescaler when assigned.
// RQ15: instruction changing program counter takes two cycles, second a no-op.
// RQ16: lone second word of two-word instruction executes as no-op.
// RQ17: add-to-file adds register to working register, destination bit steers.
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
module latod_decoder #(
   parameter logic [11:0] TIMER_ADDR = latod_pkg::TIMER_COUNT_ADDR,
   parameter logic [11:0] PORT_LO = latod_pkg::PORT_FIRST_ADDR,
   parameter logic [11:0] PORT_HI = latod_pkg::PORT_LAST_ADDR
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // instruction stream
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   output logic instr_ready,
   output logic return_pulse,
   // data memory and port pins
   output logic [11:0] dmem_rd_addr,
   input wire logic [7:0] dmem_rd_data,
   input wire logic [7:0] port_pin_level,
   output logic dmem_wr_en,
   output logic [11:0] dmem_wr_addr,
   output logic [7:0] dmem_wr_data,
   input wire logic prescaler_assigned,
   output logic prescaler_clear,
   // program memory table access
   output logic [latod_pkg::TPTR_W-1:0] prog_addr,
   output logic prog_rd_en,
   input wire logic [7:0] prog_rd_data,
   output logic prog_wr_en,
   output logic [7:0] prog_wr_data,
   // axi4-lite write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import latod_pkg::*;

   latod_s q;
   latod_s d;
   logic take;
   logic exec_go;
   logic [7:0] opc;
   logic [7:0] lit;
   logic is_add_file;
   logic is_port;
   logic [7:0] src;
   latod_aluop_e alu_op;
   logic [7:0] alu_b;
   logic [7:0] alu_res;
   logic [4:0] alu_flags;
   logic [15:0] product;
   logic [TPTR_W-1:0] pre_ptr;
   logic [31:0] wmask;

   // halting through the control register stalls the instruction stream
   assign instr_ready = !q.halt && (q.st == ST_EXEC || q.st == ST_PTR2);
   assign take = instr_valid && instr_ready;
   assign exec_go = take && (q.st == ST_EXEC);
   assign opc = instr_word[15:8];
   assign lit = instr_word[7:0];
   assign is_add_file = (instr_word[15:10] == OPC_ADD_FILE);

   // access bit clear picks the split access bank, set picks the bank
   assign dmem_rd_addr = instr_word[8] ? {q.bank_select_register, lit} :
                         (lit < ACCESS_SPLIT) ? {4'h0, lit} :
                         {ACCESS_HIGH_BANK, lit};
   // port source taken from the pins, not the output latch
   assign is_port = (dmem_rd_addr >= PORT_LO) && (dmem_rd_addr <= PORT_HI);
   assign src = is_port ? port_pin_level : dmem_rd_data; // RQ13

   // operation select for the shared adder and logic unit
   assign alu_b = is_add_file ? src : lit;
   assign alu_op = is_add_file ? ALU_ADD :
                   (opc == OPC_ADD_LIT) ? ALU_ADD :
                   (opc == OPC_SUB_LIT) ? ALU_SUB :
                   (opc == OPC_AND_LIT) ? ALU_AND :
                   (opc == OPC_OR_LIT) ? ALU_OR :
                   (opc == OPC_XOR_LIT) ? ALU_XOR : ALU_PASS;
   assign product = q.working_register * lit;
   assign pre_ptr = (instr_word[1:0] == TBL_PRE_INC) ?
                    q.tptr + 1'b1 : q.tptr;

   latod_alu u_alu (
      .op(alu_op),
      .a(q.working_register),
      .b(alu_b),
      .res(alu_res),
      .flags(alu_flags)
   );

   // byte lane mask from write strobes
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{q.wstrb[i]}};
      end
   end

   // next state: execution and register bus
   always_comb begin
      d = q;
      d.ret_p = 1'b0;
      d.psc_clr = 1'b0;
      d.dm_we = 1'b0;
      d.tbl_rd_en = 1'b0;
      d.tbl_wr_en = 1'b0;
      case (q.st)
         ST_EXEC: begin
            if (exec_go) begin
               if (is_add_file) begin
                  d.flags = alu_flags; // RQ17
                  if (instr_word[9]) begin
                     d.dm_we = 1'b1;
                     d.dm_addr = dmem_rd_addr;
                     d.dm_wdata = alu_res;
                     d.psc_clr = prescaler_assigned &&
                                 (dmem_rd_addr == TIMER_ADDR); // RQ14
                  end else begin
                     d.working_register = alu_res;
                  end
               end else if (opc == OPC_ADD_LIT || opc == OPC_SUB_LIT) begin
                  d.working_register = alu_res; // RQ1 RQ9
                  d.flags = alu_flags;
               end else if (opc == OPC_AND_LIT || opc == OPC_OR_LIT ||
                            opc == OPC_XOR_LIT) begin
                  d.working_register = alu_res; // RQ2 RQ3 RQ10
                  d.flags = (q.flags & ~FLAGS_LOGIC) |
                            (alu_flags & FLAGS_LOGIC);
               end else if (opc == OPC_LOAD_LIT) begin
                  d.working_register = lit; // RQ6
               end else if (opc == OPC_MUL_LIT) begin
                  d.prod = product; // RQ7
               end else if (opc == OPC_RET_LIT) begin
                  d.working_register = lit; // RQ8
                  d.ret_p = 1'b1;
                  d.st = ST_NOP2; // RQ15
               end else if (instr_word[15:4] == OPC_LOAD_BANK) begin
                  d.bank_select_register = instr_word[3:0]; // RQ5
               end else if (instr_word[15:6] == OPC_PTR_FIRST) begin
                  d.ptr_sel = instr_word[5:4]; // RQ4
                  d.ptr_hi = instr_word[3:0];
                  d.st = ST_PTR2;
               end else if (instr_word[15:3] == OPC_TABLE) begin
                  d.tbl_mode = instr_word[1:0]; // RQ11 RQ12
                  d.tbl_wr = instr_word[2];
                  d.tptr = pre_ptr;
                  d.tbl_addr = pre_ptr;
                  d.tbl_rd_en = !instr_word[2];
                  d.tbl_wr_en = instr_word[2];
                  d.st = ST_TBL2;
               end
               // any other word, a lone second word among them, is a no-op
            end
         end
         ST_PTR2: begin
            if (take) begin
               // the operand word is consumed here, never decoded alone
               if (q.ptr_sel < 2'(NUM_PTR)) begin
                  d.ptr[q.ptr_sel] = {q.ptr_hi, lit}; // RQ4 RQ16
               end
               d.st = ST_EXEC;
            end
         end
         ST_TBL2: begin
            if (!q.tbl_wr) begin
               d.tlat = prog_rd_data; // RQ11
            end
            if (q.tbl_mode == TBL_POST_INC) begin
               d.tptr = q.tptr + 1'b1; // RQ11 RQ12
            end else if (q.tbl_mode == TBL_POST_DEC) begin
               d.tptr = q.tptr - 1'b1;
            end
            d.st = ST_EXEC;
         end
         default: d.st = ST_EXEC; // flushed second cycle
      endcase

      // write address and data are taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         d.aw_got = 1'b1;
         d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         d.w_got = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      if (q.aw_got && q.w_got && !q.bvalid) begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = RESP_OKAY;
         // software pointer write lands after the hardware update
         if (q.awaddr == REG_CTRL) begin
            if (q.wstrb[0]) d.halt = q.wdata[0];
         end else if (q.awaddr == REG_TPTR) begin
            d.tptr = TPTR_W'((32'(q.tptr) & ~wmask) | (q.wdata & wmask));
         end else if (q.awaddr == REG_WORK || q.awaddr == REG_FLAGS ||
                      q.awaddr == REG_BANK || q.awaddr == REG_PROD ||
                      q.awaddr == REG_TLAT || q.awaddr == REG_PTR0 ||
                      q.awaddr == REG_PTR0 + 8'h04 ||
                      q.awaddr == REG_PTR0 + 8'h08) begin
            d.bresp = RESP_OKAY; // read-only, write ignored
         end else begin
            d.bresp = RESP_SLVERR;
         end
      end
      if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;

      // reads answer one cycle after the address is taken
      if (s_axi_arvalid && s_axi_arready) begin
         d.rvalid = 1'b1;
         d.rresp = RESP_OKAY;
         d.rdata = 32'h0000_0000;
         if (s_axi_araddr == REG_CTRL) begin
            d.rdata = {31'h0, q.halt};
         end else if (s_axi_araddr == REG_WORK) begin
            d.rdata = {24'h0, q.working_register};
         end else if (s_axi_araddr == REG_FLAGS) begin
            d.rdata = {27'h0, q.flags};
         end else if (s_axi_araddr == REG_BANK) begin
            d.rdata = {28'h0, q.bank_select_register};
         end else if (s_axi_araddr == REG_PROD) begin
            d.rdata = {16'h0, q.prod};
         end else if (s_axi_araddr == REG_TPTR) begin
            d.rdata = 32'(q.tptr);
         end else if (s_axi_araddr == REG_TLAT) begin
            d.rdata = {24'h0, q.tlat};
         end else if (s_axi_araddr == REG_PTR0) begin
            d.rdata = {20'h0, q.ptr[0]};
         end else if (s_axi_araddr == REG_PTR0 + 8'h04) begin
            d.rdata = {20'h0, q.ptr[1]};
         end else if (s_axi_araddr == REG_PTR0 + 8'h08) begin
            d.rdata = {20'h0, q.ptr[2]};
         end else begin
            d.rresp = RESP_SLVERR;
         end
      end
      if (q.rvalid && s_axi_rready) d.rvalid = 1'b0;
   end

   // single state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= LATOD_RST;
      end else begin
         q <= d;
      end
   end

   // outputs
   assign return_pulse = q.ret_p;
   assign dmem_wr_en = q.dm_we;
   assign dmem_wr_addr = q.dm_addr;
   assign dmem_wr_data = q.dm_wdata;
   assign prescaler_clear = q.psc_clr;
   assign prog_addr = q.tbl_addr;
   assign prog_rd_en = q.tbl_rd_en;
   assign prog_wr_en = q.tbl_wr_en;
   assign prog_wr_data = q.tlat;
   assign s_axi_awready = !q.aw_got && !q.bvalid;
   assign s_axi_wready = !q.w_got && !q.bvalid;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence ptr_first_s;
      exec_go && instr_word[15:6] == OPC_PTR_FIRST && instr_word[5:4] == 2'h0;
   endsequence
   sequence ptr_second_s;
      take && q.st == ST_PTR2;
   endsequence

   chk_add_lit_result: assert property (exec_go && opc == OPC_ADD_LIT |=> // RQ1
      q.working_register == 8'($past(q.working_register) + $past(lit)))
      else $error("add literal result wrong");
   chk_and_lit_flags: assert property (exec_go && opc == OPC_AND_LIT |=> // RQ2
      q.working_register == ($past(q.working_register) & $past(lit)) &&
      q.flags[FLG_C] == $past(q.flags[FLG_C]))
      else $error("and literal wrong");
   chk_or_lit_result: assert property (exec_go && opc == OPC_OR_LIT |=> // RQ3
      q.working_register == ($past(q.working_register) | $past(lit)) &&
      q.flags[FLG_OV] == $past(q.flags[FLG_OV]))
      else $error("or literal wrong");
   chk_load_ptr_pair: assert property (ptr_first_s ##1 ptr_second_s |=> // RQ4
      q.ptr[0] == {$past(q.ptr_hi), $past(lit)})
      else $error("pointer load wrong");
   chk_load_bank_val: assert property (exec_go && // RQ5
      instr_word[15:4] == OPC_LOAD_BANK |=>
      q.bank_select_register == $past(instr_word[3:0]) && $stable(q.flags))
      else $error("bank load wrong");
   chk_load_lit_flags: assert property (exec_go && opc == OPC_LOAD_LIT |=> // RQ6
      q.working_register == $past(lit) && $stable(q.flags))
      else $error("load literal wrong");
   chk_mul_lit_prod: assert property (exec_go && opc == OPC_MUL_LIT |=> // RQ7
      q.prod == $past(product) && $stable(q.flags))
      else $error("multiply literal wrong");
   chk_ret_two_cycle: assert property (exec_go && opc == OPC_RET_LIT |=> // RQ8
      return_pulse && !instr_ready ##1 !return_pulse && q.st == ST_EXEC)
      else $error("return literal timing wrong");
   chk_sub_lit_result: assert property (exec_go && opc == OPC_SUB_LIT |=> // RQ9
      q.working_register == 8'($past(lit) - $past(q.working_register)))
      else $error("subtract literal wrong");
   chk_xor_lit_result: assert property (exec_go && opc == OPC_XOR_LIT |=> // RQ10
      q.working_register == ($past(q.working_register) ^ $past(lit)))
      else $error("xor literal wrong");
   chk_table_two_cycle: assert property (exec_go && // RQ11
      instr_word[15:3] == OPC_TABLE |=>
      (prog_rd_en || prog_wr_en) && !instr_ready && $stable(q.flags)
      ##1 !prog_rd_en && !prog_wr_en)
      else $error("table op timing wrong");
   chk_timer_clear: assert property (prescaler_clear |-> dmem_wr_en && // RQ14
      dmem_wr_addr == TIMER_ADDR)
      else $error("prescaler clear without timer write");
endmodule : latod_decoder

/* File: verification/latod_mem_model.sv */
`timescale 1ns/100ps
module latod_mem_model (
   // clock
   input wire logic aclk,
   // data memory and pins
   input wire logic [11:0] dmem_rd_addr,
   output logic [7:0] dmem_rd_data,
   output logic [7:0] port_pin_level,
   input wire logic dmem_wr_en,
   input wire logic [11:0] dmem_wr_addr,
   input wire logic [7:0] dmem_wr_data,
   input wire logic prescaler_clear,
   // program memory
   input wire logic [latod_pkg::TPTR_W-1:0] prog_addr,
   input wire logic prog_rd_en,
   output logic [7:0] prog_rd_data,
   input wire logic prog_wr_en,
   input wire logic [7:0] prog_wr_data
);
   import latod_pkg::*;
   logic [7:0] mem [4096];
   logic [TPTR_W-1:0] last_pa = '0;
   logic [11:0] last_da = '0;
   logic [7:0] last_pw = '0;
   logic [7:0] last_dd = '0;
   logic last_psc = 1'b0;
   // port latch holds 0x11 while an outside driver pulls bit 4 low
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
      mem[12'hF80] = 8'h11;
      mem[12'hFD6] = 8'h10;
      mem[12'h050] = 8'h20;
   end
   assign dmem_rd_data = mem[dmem_rd_addr];
   assign port_pin_level = 8'h01;
   // data is only valid in the read cycle; otherwise it shows the inverse
   assign prog_rd_data = prog_rd_en ? (prog_addr[7:0] ^ 8'hA5)
                                    : ~(prog_addr[7:0] ^ 8'hA5);
   // capture program accesses and data writes so the bench can compare address and data
   always @(posedge aclk) begin
      if (prog_rd_en || prog_wr_en) last_pa <= prog_addr;
      if (prog_wr_en) last_pw <= prog_wr_data;
      if (dmem_wr_en) begin
         mem[dmem_wr_addr] <= dmem_wr_data;
         last_da <= dmem_wr_addr;
         last_dd <= dmem_wr_data;
         last_psc <= prescaler_clear;
      end
   end
endmodule : latod_mem_model

/* File: verification/literal_and_table_op_decoder_bench.sv */
`timescale 1ns/100ps
module literal_and_table_op_decoder_bench;
   import latod_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, instr_valid = 1'b0;
   logic prescaler_assigned = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic instr_ready, return_pulse, dmem_wr_en, prescaler_clear;
   logic prog_rd_en, prog_wr_en;
   logic [11:0] dmem_rd_addr, dmem_wr_addr;
   logic [7:0] dmem_rd_data, port_pin_level, dmem_wr_data;
   logic [7:0] prog_rd_data, prog_wr_data;
   logic [TPTR_W-1:0] prog_addr;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic [1:0] s_axi_bresp, s_axi_rresp, wresp;
   int err_count = 0, check_count = 0;
   // literal ops with expected working register and flags after each
   logic [15:0] lw [9] = '{16'h0E10, 16'h0F15, 16'h0FDB, 16'h0805,
      16'h0B04, 16'h0980, 16'h0A84, 16'h0E7F, 16'h0D03};
   logic [7:0] ew [9] = '{8'h10, 8'h25, 8'h00, 8'h05, 8'h04, 8'h84,
      8'h00, 8'h7F, 8'h7F};
   logic [4:0] ef [9] = '{5'h00, 5'h00, 5'h07, 5'h03, 5'h03, 5'h13,
      5'h07, 5'h07, 5'h07};

   latod_decoder uut (.*);
   latod_mem_model mdl (.*);

   // free-running 200 MHz clock
   initial begin
      forever #2.5 aclk = ~aclk;
   end

   task chk(string n, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   // word is held until the edge at which instr_ready is high
   task ex(logic [15:0] w);
      @(posedge aclk);
      instr_word <= w;
      instr_valid <= 1'b1;
      do @(negedge aclk); while (instr_ready !== 1'b1);
      @(posedge aclk);
      instr_valid <= 1'b0;
   endtask : ex

   // address and data offered together, each dropped once taken
   task wr(logic [7:0] a, logic [31:0] d);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (!ad && s_axi_awready === 1'b1) begin
            ad = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!wd && s_axi_wready === 1'b1) begin
            wd = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      wresp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd

   task rc(string n, logic [7:0] a, logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(n, e, d);
   endtask : rc

   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #50000;
      err_count++;
      $display("[FAIL] watchdog expected finish seen hang");
      end_of_test();
   end

   // main sequence
   initial begin
      logic [21:0] p, a;
      logic [7:0] lat;
      logic [31:0] d;
      logic [1:0] r;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         ex(lw[i]);
         rc("work", REG_WORK, ew[i]);
         rc("flags", REG_FLAGS, ef[i]);
      end
      rc("product", REG_PROD, 32'h017D);
      ex(16'h0105);
      rc("bank", REG_BANK, 32'h5);
      $display("literal test done");
      ex(16'hEE1A);
      ex(16'hF0BC);
      ex(16'hF0FF);
      ex(16'hEE03);
      ex(16'hF045);
      rc("ptr1", REG_PTR0 + 8'h04, 32'hABC);
      rc("ptr0", REG_PTR0, 32'h345);
      rc("work", REG_WORK, 32'h7F);
      ex(16'h0C42);
      @(negedge aclk);
      chk("return", 1, return_pulse);
      chk("ready", 0, instr_ready);
      rc("work", REG_WORK, 32'h42);
      $display("pointer and return test done");
      // every table mode: reads fill the latch, writes send it out
      p = 22'h100;
      lat = 8'h00;
      wr(REG_TPTR, 32'h100);
      for (int m = 0; m < 8; m++) begin
         ex(16'h0008 | 16'(m));
         if (m[1:0] == TBL_PRE_INC) p++;
         a = p;
         if (m[1:0] == TBL_POST_INC) p++;
         else if (m[1:0] == TBL_POST_DEC) p--;
         if (!m[2]) lat = a[7:0] ^ 8'hA5;
         rc("tptr", REG_TPTR, p);
         rc("latch", REG_TLAT, lat);
         chk("prog addr", a, mdl.last_pa);
         if (m[2]) chk("prog data", lat, mdl.last_pw);
      end
      rc("flags", REG_FLAGS, 32'h07);
      $display("table test done");
      ex(16'h0E02);
      ex(16'h2680);
      rc("flags", REG_FLAGS, 32'h00);
      chk("port addr", 12'hF80, mdl.last_da);
      chk("port data", 8'h03, mdl.last_dd);
      for (int k = 0; k < 2; k++) begin
         prescaler_assigned <= k[0];
         ex(16'h26D6);
         rc("work", REG_WORK, 32'h02);
         chk("timer data", 8'h12 + 8'(2 * k), mdl.last_dd);
         chk("prescale", k, mdl.last_psc);
      end
      ex(16'h2450);
      rc("work", REG_WORK, 32'h22);
      $display("file test done");
      wr(REG_WORK, 32'hFF);
      chk("ro resp", RESP_OKAY, wresp);
      rc("work", REG_WORK, 32'h22);
      rd(8'h40, d, r);
      chk("unmapped resp", RESP_SLVERR, r);
      chk("unmapped data", 32'h0, d);
      wr(REG_CTRL, 32'h1);
      @(negedge aclk);
      chk("halt ready", 0, instr_ready);
      rc("ctrl", REG_CTRL, 32'h1);
      wr(REG_CTRL, 32'h0);
      $display("register test done");
      end_of_test();
   end
endmodule : literal_and_table_op_decoder_bench
